//--- rtl/psl_pkg.sv
// constants, register map and carrier types of the strap latch
package psl_pkg;

  localparam int          APB_AW          = 8;
  localparam int          REG_W           = 16;

  // register byte offsets
  localparam logic [7:0]  OFF_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_CTRL_A      = 8'h04;
  localparam logic [7:0]  OFF_ADV_A       = 8'h08;
  localparam logic [7:0]  OFF_CTRL_B      = 8'h0c;
  localparam logic [7:0]  OFF_ADV_B       = 8'h10;
  localparam logic [7:0]  OFF_STRAP_STAT  = 8'h14;

  // basic control fields
  localparam int          CTRL_SPEED_BIT  = 13;
  localparam int          CTRL_NEG_BIT    = 12;
  localparam int          CTRL_DUPLEX_BIT = 8;
  localparam logic [15:0] CTRL_WR_MASK    = 16'h3100;
  localparam logic [15:0] CTRL_RST_VAL    = 16'h0000;

  // advertisement fields
  localparam int          ADV_10HD_BIT    = 5;
  localparam int          ADV_10FD_BIT    = 6;
  localparam int          ADV_100HD_BIT   = 7;
  localparam int          ADV_100FD_BIT   = 8;
  localparam int          ADV_ABIL_LSB    = 5;
  localparam logic [15:0] ADV_WR_MASK     = 16'h01e0;
  localparam logic [15:0] ADV_SELECTOR    = 16'h0001;

  // address control and strap status field positions
  localparam int          ADDR_A_LSB      = 0;
  localparam int          ADDR_B_LSB      = 8;
  localparam int          STAT_A_LSB      = 0;
  localparam int          STAT_B_LSB      = 4;
  localparam int          STAT_ADDR_LSB   = 8;

  // low management address bit names the port
  localparam logic        PORT_A_ID       = 1'b0;
  localparam logic        PORT_B_ID       = 1'b1;

  // shared pins of one port, strap role noted beside each
  typedef struct packed {
    logic rxd1;       // address strap, high bit of the pair
    logic rxd0;       // address strap, low bit of the pair
    logic col;        // fiber_select_strap
    logic led_act;    // negotiate_enable_strap
    logic led_speed;  // capability_strap_hi
    logic led_link;   // capability_strap_lo
  } psl_pins_t;

  // captured mode straps of one port
  typedef struct packed {
    logic fiber;
    logic neg;
    logic cap_hi;
    logic cap_lo;
  } psl_strap_t;

  // operating configuration handed to the port
  typedef struct packed {
    logic       fiber;
    logic       neg_en;
    logic       speed_100;
    logic       full_dup;
    logic [4:0] mgmt_addr;
    logic [3:0] adv;
  } psl_cfg_t;

endpackage : psl_pkg

//--- rtl/psl_port_decode.sv
// per-port decode of captured straps into address and register defaults
module psl_port_decode #(
  parameter logic PORT_ID = 1'b0
) (
  input  wire logic [4:1]              addr_hi,   // strapped address bits
  input  wire psl_pkg::psl_strap_t     strap,     // mode straps
  output logic [4:0]                   mgmt_addr, // port address
  output logic [psl_pkg::REG_W-1:0]    ctrl_init, // basic control default
  output logic [psl_pkg::REG_W-1:0]    adv_init   // advertisement default
);
  import psl_pkg::*;

  always_comb begin
    mgmt_addr = {addr_hi, PORT_ID};
    ctrl_init = CTRL_RST_VAL;
    adv_init  = ADV_SELECTOR;
    if (strap.fiber) begin
      // fiber never negotiates; only the low capability bit counts
      ctrl_init[CTRL_SPEED_BIT]  = 1'b1;
      ctrl_init[CTRL_DUPLEX_BIT] = strap.cap_lo;
      adv_init[ADV_100HD_BIT]    = 1'b1;
      adv_init[ADV_100FD_BIT]    = strap.cap_lo;
    end else if (strap.neg) begin
      ctrl_init[CTRL_NEG_BIT] = 1'b1;
      unique case ({strap.cap_hi, strap.cap_lo})
        2'b00: begin
          adv_init[ADV_10HD_BIT] = 1'b1;
          adv_init[ADV_10FD_BIT] = 1'b1;
        end
        2'b01: begin
          adv_init[ADV_100HD_BIT] = 1'b1;
          adv_init[ADV_100FD_BIT] = 1'b1;
        end
        2'b10: begin
          adv_init[ADV_10HD_BIT]  = 1'b1;
          adv_init[ADV_100HD_BIT] = 1'b1;
        end
        2'b11: begin
          adv_init[ADV_10HD_BIT]  = 1'b1;
          adv_init[ADV_10FD_BIT]  = 1'b1;
          adv_init[ADV_100HD_BIT] = 1'b1;
          adv_init[ADV_100FD_BIT] = 1'b1;
        end
      endcase
    end else begin
      ctrl_init[CTRL_SPEED_BIT]  = strap.cap_hi;
      ctrl_init[CTRL_DUPLEX_BIT] = strap.cap_lo;
      adv_init[ADV_ABIL_LSB + {strap.cap_hi, strap.cap_lo}] = 1'b1;
    end
  end

endmodule : psl_port_decode

//--- rtl/psl_strap_latch.sv
// strap capture, register load and pin hand-back for a dual-port phy
////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////
module psl_strap_latch (
  input  wire logic                 clk,       // 10 MHz clock
  input  wire logic                 srst,      // hardware reset
  input  wire logic                 psel,      // apb select
  input  wire logic                 penable,   // apb enable
  input  wire logic                 pwrite,    // apb direction
  input  wire logic [7:0]           paddr,     // apb byte address
  input  wire logic [31:0]          pwdata,    // apb write data
  output logic      [31:0]          prdata,    // apb read data
  output logic                      pready,    // apb ready
  output logic                      pslverr,   // apb error
  input  wire psl_pkg::psl_pins_t   pin_a_i,   // port a pin levels
  input  wire psl_pkg::psl_pins_t   pin_b_i,   // port b pin levels
  input  wire psl_pkg::psl_pins_t   func_a_i,  // port a functional drive
  input  wire psl_pkg::psl_pins_t   func_b_i,  // port b functional drive
  output psl_pkg::psl_pins_t        pin_a_o,   // port a pin drive
  output psl_pkg::psl_pins_t        pin_b_o,   // port b pin drive
  output psl_pkg::psl_pins_t        pin_a_oe,  // port a drive enable
  output psl_pkg::psl_pins_t        pin_b_oe,  // port b drive enable
  output psl_pkg::psl_cfg_t         cfg_a,     // port a configuration
  output psl_pkg::psl_cfg_t         cfg_b      // port b configuration
);
  import psl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // strap capture

  logic [4:1]  addr_hi_reg, addr_hi_next;
  psl_strap_t  strap_a_reg, strap_a_next;
  psl_strap_t  strap_b_reg, strap_b_next;
  logic [4:1]  pin_addr;
  logic [4:0]  mgmt_a, mgmt_b;
  logic [15:0] ctrl_a_init, adv_a_init, ctrl_b_init, adv_b_init;

  // rxd pins of both ports form the shared address strap; the pins float
  // in reset, so an unstrapped pin settles at its weak pull-down
  assign pin_addr = {pin_b_i.rxd1, pin_b_i.rxd0,
                     pin_a_i.rxd1, pin_a_i.rxd0};

  always_comb begin
    addr_hi_next = addr_hi_reg;
    strap_a_next = strap_a_reg;
    strap_b_next = strap_b_reg;
    // follows the pins for the whole reset, frozen after it
    if (srst) begin
      addr_hi_next = pin_addr;
      strap_a_next = {pin_a_i.col, pin_a_i.led_act,
                      pin_a_i.led_speed, pin_a_i.led_link};
      strap_b_next = {pin_b_i.col, pin_b_i.led_act,
                      pin_b_i.led_speed, pin_b_i.led_link};
    end
  end

  always_ff @(posedge clk) begin
    addr_hi_reg <= addr_hi_next;
    strap_a_reg <= strap_a_next;
    strap_b_reg <= strap_b_next;
  end

  // decode the values being captured so the register load lines up
  psl_port_decode #(.PORT_ID(PORT_A_ID)) u_dec_a (
    .addr_hi   (addr_hi_next),
    .strap     (strap_a_next),
    .mgmt_addr (mgmt_a),
    .ctrl_init (ctrl_a_init),
    .adv_init  (adv_a_init)
  );

  psl_port_decode #(.PORT_ID(PORT_B_ID)) u_dec_b (
    .addr_hi   (addr_hi_next),
    .strap     (strap_b_next),
    .mgmt_addr (mgmt_b),
    .ctrl_init (ctrl_b_init),
    .adv_init  (adv_b_init)
  );

  ////////////////////////////////////////////////////////////////////////
  // control registers and apb slave

  logic [15:0] ctrl_a_reg, ctrl_a_next, adv_a_reg, adv_a_next;
  logic [15:0] ctrl_b_reg, ctrl_b_next, adv_b_reg, adv_b_next;
  logic [31:0] prdata_reg, prdata_next, rd_data;
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic        hit, wr;

  // software may change speed, duplex and negotiation, but a fiber
  // port stays at 100 Mb/s without negotiation
  function automatic logic [15:0] ctrl_fix(input logic [15:0] d,
                                           input logic        fib);
    logic [15:0] v;
    v = d & CTRL_WR_MASK;
    if (fib) begin
      v[CTRL_SPEED_BIT] = 1'b1;
      v[CTRL_NEG_BIT]   = 1'b0;
    end
    return v;
  endfunction : ctrl_fix

  always_comb begin
    hit     = 1'b1;
    rd_data = '0;
    unique case (paddr)
      OFF_ADDR_CTRL: begin
        rd_data[ADDR_A_LSB +: 5] = mgmt_a;
        rd_data[ADDR_B_LSB +: 5] = mgmt_b;
      end
      OFF_CTRL_A:     rd_data[15:0] = ctrl_a_reg;
      OFF_ADV_A:      rd_data[15:0] = adv_a_reg;
      OFF_CTRL_B:     rd_data[15:0] = ctrl_b_reg;
      OFF_ADV_B:      rd_data[15:0] = adv_b_reg;
      OFF_STRAP_STAT: begin
        rd_data[STAT_A_LSB +: 4]    = strap_a_reg;
        rd_data[STAT_B_LSB +: 4]    = strap_b_reg;
        rd_data[STAT_ADDR_LSB +: 4] = addr_hi_reg;
      end
      default:        hit = 1'b0;
    endcase
  end

  // one wait state: ready comes a cycle into the access phase
  assign wr = psel & penable & pready_reg & pwrite & hit;

  always_comb begin
    ctrl_a_next  = ctrl_a_reg;
    adv_a_next   = adv_a_reg;
    ctrl_b_next  = ctrl_b_reg;
    adv_b_next   = adv_b_reg;
    pready_next  = psel & penable & ~pready_reg & ~srst;
    prdata_next  = (pready_next & ~pwrite & hit) ? rd_data : '0;
    pslverr_next = pready_next & ~hit;
    if (srst) begin
      ctrl_a_next = ctrl_a_init;
      adv_a_next  = adv_a_init;
      ctrl_b_next = ctrl_b_init;
      adv_b_next  = adv_b_init;
    end else if (wr) begin
      unique case (paddr)
        OFF_CTRL_A: ctrl_a_next = ctrl_fix(pwdata[15:0], strap_a_reg.fiber);
        OFF_CTRL_B: ctrl_b_next = ctrl_fix(pwdata[15:0], strap_b_reg.fiber);
        OFF_ADV_A:  adv_a_next  = (pwdata[15:0] & ADV_WR_MASK) | ADV_SELECTOR;
        OFF_ADV_B:  adv_b_next  = (pwdata[15:0] & ADV_WR_MASK) | ADV_SELECTOR;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    ctrl_a_reg  <= ctrl_a_next;
    adv_a_reg   <= adv_a_next;
    ctrl_b_reg  <= ctrl_b_next;
    adv_b_reg   <= adv_b_next;
    prdata_reg  <= prdata_next;
    pready_reg  <= pready_next;
    pslverr_reg <= pslverr_next;
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////
  // pin hand-back and configuration outputs

  psl_pins_t pa_o_reg, pa_o_next, pb_o_reg, pb_o_next;
  psl_pins_t pa_oe_reg, pa_oe_next, pb_oe_reg, pb_oe_next;
  psl_cfg_t  cfg_a_reg, cfg_a_next, cfg_b_reg, cfg_b_next;

  always_comb begin
    // pins float during reset so the board resistors set the level
    pa_oe_next = srst ? '0 : '1;
    pb_oe_next = srst ? '0 : '1;
    pa_o_next  = srst ? '0 : func_a_i;
    pb_o_next  = srst ? '0 : func_b_i;
    cfg_a_next = {strap_a_reg.fiber, ctrl_a_reg[CTRL_NEG_BIT],
                  ctrl_a_reg[CTRL_SPEED_BIT], ctrl_a_reg[CTRL_DUPLEX_BIT],
                  mgmt_a, adv_a_reg[ADV_ABIL_LSB +: 4]};
    cfg_b_next = {strap_b_reg.fiber, ctrl_b_reg[CTRL_NEG_BIT],
                  ctrl_b_reg[CTRL_SPEED_BIT], ctrl_b_reg[CTRL_DUPLEX_BIT],
                  mgmt_b, adv_b_reg[ADV_ABIL_LSB +: 4]};
  end

  always_ff @(posedge clk) begin
    pa_oe_reg <= pa_oe_next;
    pb_oe_reg <= pb_oe_next;
    pa_o_reg  <= pa_o_next;
    pb_o_reg  <= pb_o_next;
    cfg_a_reg <= cfg_a_next;
    cfg_b_reg <= cfg_b_next;
  end

  assign pin_a_oe = pa_oe_reg;
  assign pin_b_oe = pb_oe_reg;
  assign pin_a_o  = pa_o_reg;
  assign pin_b_o  = pb_o_reg;
  assign cfg_a    = cfg_a_reg;
  assign cfg_b    = cfg_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_addr_capture: assert property (
    $fell(srst) |-> addr_hi_reg == $past(pin_addr))
    else $error("address strap not captured at release");

  a_port_addr: assert property (
    !$past(srst) |-> cfg_a.mgmt_addr == {addr_hi_reg, 1'b0}
                  && cfg_b.mgmt_addr == {addr_hi_reg, 1'b1})
    else $error("port management address wrong");

  a_strap_hold: assert property (
    !$past(srst) |-> $stable(addr_hi_reg) && $stable(strap_a_reg)
                  && $stable(strap_b_reg))
    else $error("captured strap changed after release");

  a_pins_release: assert property (
    $fell(srst) |=> pin_a_oe == '1 && pin_b_oe == '1
                 && pin_a_o == $past(func_a_i))
    else $error("pins not handed back after release");

  a_fiber_fixed: assert property (
    !$past(srst) && cfg_b.fiber |-> cfg_b.speed_100 && !cfg_b.neg_en)
    else $error("fiber port not at forced 100");

  a_fiber_duplex: assert property (
    $fell(srst) && strap_b_reg.fiber
      |-> ctrl_b_reg[CTRL_DUPLEX_BIT] == strap_b_reg.cap_lo)
    else $error("fiber duplex not from low capability bit");

  a_forced_mode: assert property (
    $fell(srst) && !strap_a_reg.fiber && !strap_a_reg.neg
      |-> !ctrl_a_reg[CTRL_NEG_BIT]
       && ctrl_a_reg[CTRL_SPEED_BIT] == strap_a_reg.cap_hi
       && ctrl_a_reg[CTRL_DUPLEX_BIT] == strap_a_reg.cap_lo)
    else $error("forced mode not loaded from straps");

  a_neg_mode: assert property (
    $fell(srst) && !strap_a_reg.fiber && strap_a_reg.neg
      |-> ctrl_a_reg[CTRL_NEG_BIT] && !ctrl_a_reg[CTRL_SPEED_BIT]
       && adv_a_reg[ADV_ABIL_LSB +: 4] != 4'h0)
    else $error("negotiation not enabled by strap");

  a_apb_ready: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not one wait state");

  // fiber advertises 100 Mb/s only, full duplex only when strapped
  a_fiber_adv: assert property (
    $fell(srst) && strap_b_reg.fiber
      |-> adv_b_reg[ADV_100HD_BIT] && !adv_b_reg[ADV_10HD_BIT]
       && !adv_b_reg[ADV_10FD_BIT]
       && adv_b_reg[ADV_100FD_BIT] == strap_b_reg.cap_lo)
    else $error("fiber advertisement not from low capability bit");

  a_ctrl_load: assert property (
    $fell(srst) |-> (ctrl_a_reg[CTRL_NEG_BIT]
                      == (strap_a_reg.neg && !strap_a_reg.fiber))
                 && (ctrl_b_reg[CTRL_NEG_BIT]
                      == (strap_b_reg.neg && !strap_b_reg.fiber)))
    else $error("negotiation bit not loaded from straps");

  // a forced port advertises only the single mode that it runs
  a_forced_adv: assert property (
    $fell(srst) && !strap_a_reg.fiber && !strap_a_reg.neg
      |-> $onehot(adv_a_reg[ADV_ABIL_LSB +: 4])
       && adv_a_reg[ADV_ABIL_LSB + strap_a_reg[1:0]])
    else $error("forced advertisement not from capability bits");

  a_fiber_select: assert property (
    !$past(srst) |-> cfg_a.fiber == strap_a_reg.fiber
                  && cfg_b.fiber == strap_b_reg.fiber)
    else $error("fiber mode not taken from its strap");

  a_pins_follow: assert property (
    !$past(srst) |-> pin_b_oe == '1 && pin_b_o == $past(func_b_i))
    else $error("port b pins not in their functional role");

  a_cfg_follow: assert property (
    !$past(srst) |-> cfg_a.speed_100 == $past(ctrl_a_reg[CTRL_SPEED_BIT])
                  && cfg_a.full_dup == $past(ctrl_a_reg[CTRL_DUPLEX_BIT]))
    else $error("configuration does not follow the control register");

  a_apb_error: assert property (
    psel && penable && !pready && !hit |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

endmodule : psl_strap_latch

//--- dv/psl_board.sv
// board side of the straps: resistors, weak pulls and pin resolution
module psl_board (
  input  wire psl_pkg::psl_pins_t fit_a, // resistor fitted, port a
  input  wire psl_pkg::psl_pins_t res_a, // resistor level, port a
  input  wire psl_pkg::psl_pins_t drv_a, // device drive, port a
  input  wire psl_pkg::psl_pins_t oe_a,  // device enable, port a
  input  wire psl_pkg::psl_pins_t fit_b, // resistor fitted, port b
  input  wire psl_pkg::psl_pins_t res_b, // resistor level, port b
  input  wire psl_pkg::psl_pins_t drv_b, // device drive, port b
  input  wire psl_pkg::psl_pins_t oe_b,  // device enable, port b
  output psl_pkg::psl_pins_t      lvl_a, // wire level, port a
  output psl_pkg::psl_pins_t      lvl_b  // wire level, port b
);
  timeunit 1ns;
  timeprecision 1ns;
  import psl_pkg::*;
  // weak pulls: address and fiber pins low, mode pins high
  localparam logic [5:0] PULL = 6'h07;
  ////////////////////////////////////////////////////////////////////////
  // a driving device wins over any resistor; else resistor, else pull
  assign lvl_a = psl_pins_t'((oe_a & drv_a) |
                 (~oe_a & ((fit_a & res_a) | (~fit_a & PULL))));
  assign lvl_b = psl_pins_t'((oe_b & drv_b) |
                 (~oe_b & ((fit_b & res_b) | (~fit_b & PULL))));
endmodule : psl_board

//--- dv/tb_psl_strap_latch.sv
// self-checking bench: strap sweep, pin hand-back and apb register map
module tb_psl_strap_latch;
  timeunit 1ns;
  timeprecision 1ns;
  import psl_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  psl_pins_t   lvl_a, lvl_b, pin_a_o, pin_b_o, oe_a, oe_b;
  psl_pins_t   func_a = '0, func_b = '0, fit_a = '0, fit_b = '0;
  psl_pins_t   res_a = '0, res_b = '0;
  psl_cfg_t    cfg_a, cfg_b;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [3:0]  aneg [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  psl_strap_latch dut_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a_i(lvl_a), .pin_b_i(lvl_b), .func_a_i(func_a), .func_b_i(func_b),
    .pin_a_o(pin_a_o), .pin_b_o(pin_b_o), .pin_a_oe(oe_a), .pin_b_oe(oe_b),
    .cfg_a(cfg_a), .cfg_b(cfg_b));
  psl_board board_u (.fit_a(fit_a), .res_a(res_a), .drv_a(pin_a_o),
    .oe_a(oe_a), .fit_b(fit_b), .res_b(res_b), .drv_b(pin_b_o),
    .oe_b(oe_b), .lvl_a(lvl_a), .lvl_b(lvl_b));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; the idle edge at the start keeps transfers apart
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // read at the rising edge, before the slave's updates of that edge land
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: pready %h exp %h", $time, pready, 1'b1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rreg(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd & m, e);
  endtask : rreg
  // straps are applied with reset; functional drive is their inverse
  task automatic boot(input psl_pins_t sa, input psl_pins_t sb,
                      input psl_pins_t ft);
    @(posedge clk);
    fit_a <= ft;
    fit_b <= ft;
    res_a <= sa;
    res_b <= sb;
    func_a <= psl_pins_t'(~sa);
    func_b <= psl_pins_t'(~sb);
    srst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({20'h0, oe_a, oe_b}, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({20'h0, oe_a, oe_b}, 32'hfff);
    chk({20'h0, pin_a_o, pin_b_o}, {20'h0, func_a, func_b});
  endtask : boot
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [3:0]  k;
    logic        ng;
    logic [3:0]  av;
    logic [12:0] ea;
    logic [31:0] rd;
    logic        er;
    boot('0, '0, '0);
    chk({19'h0, cfg_a & 13'h19ff}, 32'h080f);
    chk({19'h0, cfg_b & 13'h19ff}, 32'h081f);
    $display("test defaults done");
    for (int i = 0; i < 32; i++) begin
      k = i[3:0];
      ng = i[4];
      boot(psl_pins_t'({k[1], k[0], 1'b0, ng, k[1], k[0]}),
           psl_pins_t'({k[3], k[2], 1'b1, k[2], k[3], k[0]}), '1);
      av = ng ? aneg[k[1:0]] : 4'(4'h1 << k[1:0]);
      ea = {1'b0, ng, ng ? 2'b00 : k[1:0], k, 1'b0, av};
      // speed and duplex are left open while negotiating
      chk({19'h0, cfg_a & (ng ? 13'h19ff : 13'h1fff)}, {19'h0, ea});
      chk({19'h0, cfg_b}, {19'h0, 3'b101, k[0], k, 1'b1,
          k[0] ? 4'hc : 4'h4});
      rreg(OFF_ADDR_CTRL, '1, {19'h0, k, 1'b1, 3'h0, k, 1'b0});
      rreg(OFF_CTRL_A, ng ? 32'h1000 : '1,
           ng ? 32'h1000 : {18'h0, k[1], 4'h0, k[0], 8'h0});
      rreg(OFF_ADV_A, '1, {23'h0, av, 5'h01});
      rreg(OFF_CTRL_B, '1, {18'h0, 1'b1, 4'h0, k[0], 8'h0});
      rreg(OFF_ADV_B, '1, {23'h0, k[0] ? 4'hc : 4'h4, 5'h01});
      rreg(OFF_STRAP_STAT, '1, {20'h0, k, 1'b1, k[2], k[3], k[0],
           1'b0, ng, k[1], k[0]});
    end
    $display("test strap sweep done");
    apb(1'b1, OFF_CTRL_A, 32'hffff_ffff, rd, er);
    rreg(OFF_CTRL_A, '1, 32'h0000_3100);
    apb(1'b1, OFF_CTRL_B, 32'h0000_1000, rd, er);
    rreg(OFF_CTRL_B, '1, 32'h0000_2000);
    apb(1'b1, OFF_ADDR_CTRL, 32'h0, rd, er);
    rreg(OFF_ADDR_CTRL, '1, 32'h0000_1f1e);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test register access done");
    summarize();
  end
endmodule : tb_psl_strap_latch
